// ### lso_logic_unit.sv
/*
  logical and selective instruction datapath: holds the accumulator,
  mask register and x register, runs one operation per start pulse,
  writes back replace-class results and reports the skip decision.
  assumes the sequencer holds op, operand and skip code stable from
  start until done and fetches the operand before start.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lso_consts.svh"
module lso_logic_unit #(
  parameter int WORD_W = `LSO_WORD_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   start,
  input  wire logic [`LSO_OP_W-1:0]   op,
  input  wire logic [`LSO_SKIP_W-1:0] skip_code,
  input  wire logic [WORD_W-1:0]      operand,
  input  wire logic                   load_a,
  input  wire logic                   load_q,
  input  wire logic [WORD_W-1:0]      load_data,
  output logic                        busy,
  output logic                        done,
  output logic                        skip,
  output logic                        overflow,
  output logic                        mem_we,
  output logic [WORD_W-1:0]           mem_wdata,
  output logic [WORD_W-1:0]           acc,
  output logic [WORD_W-1:0]           mask_q
);
  lso_pkg::lso_state_t state_r;     // sequencing state
  lso_pkg::lso_state_t state_nxt;   // next state
  logic [WORD_W-1:0] a_r;           // accumulator
  logic [WORD_W-1:0] a_nxt;         // accumulator next value
  logic [WORD_W-1:0] q_r;           // mask register
  logic [WORD_W-1:0] x_r;           // substitute temporary
  logic [WORD_W-1:0] x_nxt;         // temporary next value
  logic              done_r;        // completion pulse
  logic              skip_r;        // skip decision
  logic              ovf_r;         // arithmetic overflow
  logic              ovf_nxt;       // overflow next value
  logic              we_r;          // write-back strobe
  logic              we_nxt;        // write-back strobe next
  logic [WORD_W-1:0] wd_r;          // write-back word
  logic [WORD_W-1:0] wd_nxt;        // write-back word next

  // one adder serves masked add and subtract; subtract feeds the
  // complement in, trading a mux for a second carry chain
  lso_alu_if alu_p ();
  lso_oc_adder u_add (.p(alu_p));

  // masked operand shared by every logical product form except the store form, which masks A
  wire [WORD_W-1:0] lp_w = q_r & operand;
  // op class decodes, read by the steering and the skip logic
  wire is_sub_w   = (op == `LSO_OP_SUB_MASK) || (op == `LSO_OP_WB_SUB);
  wire is_arith_w = is_sub_w || (op == `LSO_OP_ADD_MASK) ||
                    (op == `LSO_OP_WB_ADD);
  wire is_merge_w = (op == `LSO_OP_MERGE) || (op == `LSO_OP_WB_MERGE);
  wire is_parity_w = (op == `LSO_OP_LOAD_AND) || (op == `LSO_OP_WB_AND);
  // replace-class ops write their result back to the operand cell
  wire is_repl_w  = (op == `LSO_OP_WB_AND)   || (op == `LSO_OP_WB_ADD) ||
                    (op == `LSO_OP_WB_SUB)   || (op == `LSO_OP_WB_SET) ||
                    (op == `LSO_OP_WB_INVERT) || (op == `LSO_OP_WB_ZEROS) ||
                    (op == `LSO_OP_WB_MERGE);

  assign alu_p.a_in = a_r;
  assign alu_p.b_in = lp_w;
  assign alu_p.sub  = is_sub_w;

  // single-step result for all ops except substitute
  logic [WORD_W-1:0] res_w;
  always_comb begin
    res_w = a_r;
    case (op)
      `LSO_OP_LOAD_AND, `LSO_OP_WB_AND: res_w = lp_w;
      `LSO_OP_ADD_MASK, `LSO_OP_WB_ADD: res_w = alu_p.sum;
      `LSO_OP_SUB_MASK, `LSO_OP_WB_SUB: res_w = alu_p.sum;
      `LSO_OP_SET,    `LSO_OP_WB_SET:    res_w = a_r | operand;
      `LSO_OP_INVERT, `LSO_OP_WB_INVERT: res_w = a_r ^ operand;
      `LSO_OP_ZEROS,  `LSO_OP_WB_ZEROS:  res_w = a_r & ~operand;
      default: res_w = a_r; // store form and unused codes keep A
    endcase
  end

  // skip test on the final accumulator; parity replaces Q sign tests for the two masked loads
  function automatic logic skip_eval(input logic [WORD_W-1:0] a,
                                     input logic [WORD_W-1:0] q,
                                     input logic [`LSO_SKIP_W-1:0] c,
                                     input logic par);
    logic r;
    r = 1'b0;
    case (c)
      `LSO_SKIP_NONE:   r = 1'b0;
      `LSO_SKIP_ALWAYS: r = 1'b1;
      `LSO_SKIP_SKIP_IF_MASK_REG_POSITIVE:   r = par ? ~(^a) : ~q[WORD_W-1];
      `LSO_SKIP_SKIP_IF_MASK_REG_NEGATIVE:   r = par ? (^a) : q[WORD_W-1];
      `LSO_SKIP_AZERO:  r = (a == '0);
      `LSO_SKIP_ANOT:   r = (a != '0);
      `LSO_SKIP_APOS:   r = ~a[WORD_W-1];
      `LSO_SKIP_ANEG:   r = a[WORD_W-1];
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // next-state and datapath steering
  always_comb begin
    state_nxt = state_r;
    a_nxt     = a_r;
    x_nxt     = x_r;
    we_nxt    = 1'b0;
    wd_nxt    = wd_r;
    ovf_nxt   = ovf_r;
    case (state_r)
      lso_pkg::LSO_IDLE: begin
        if (start) begin
          // substitute step one: clear A under the mask
          if (is_merge_w) begin
            a_nxt     = a_r & ~q_r;
            state_nxt = lso_pkg::LSO_STEP2;
          end else begin
            a_nxt     = res_w;
            if (is_arith_w) ovf_nxt = alu_p.ovf;
            if (op == `LSO_OP_STORE_AND) begin
              we_nxt = 1'b1;
              wd_nxt = q_r & a_r;
            end else if (is_repl_w) begin
              we_nxt = 1'b1;
              wd_nxt = res_w;
            end
            state_nxt = lso_pkg::LSO_DONE;
          end
        end
      end
      // substitute step two: latch Y AND Q in X
      lso_pkg::LSO_STEP2: begin
        x_nxt     = lp_w;
        state_nxt = lso_pkg::LSO_STEP3;
      end
      // substitute step three: set A where X holds ones
      lso_pkg::LSO_STEP3: begin
        a_nxt     = a_r | x_r;
        we_nxt    = is_repl_w;
        wd_nxt    = a_r | x_r;
        state_nxt = lso_pkg::LSO_DONE;
      end
      // done state lets A settle before the skip test reads it
      lso_pkg::LSO_DONE:  state_nxt = lso_pkg::LSO_IDLE;
      default:            state_nxt = lso_pkg::LSO_IDLE;
    endcase
  end

  // state and control flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= lso_pkg::LSO_IDLE;
      done_r  <= 1'b0;
      skip_r  <= 1'b0;
      we_r    <= 1'b0;
      ovf_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r  <= (state_r == lso_pkg::LSO_DONE);
      we_r    <= we_nxt;
      ovf_r   <= ovf_nxt;
      // skip is judged once the result sits in A
      if (state_r == lso_pkg::LSO_DONE)
        skip_r <= skip_eval(a_r, q_r, skip_code, is_parity_w);
    end
  end

  // data registers; direct loads only accepted while idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_r  <= `LSO_A_RESET;
      q_r  <= `LSO_Q_RESET;
      x_r  <= '0;
      wd_r <= '0;
    end else begin
      x_r  <= x_nxt;
      wd_r <= wd_nxt;
      if (state_r == lso_pkg::LSO_IDLE && !start && load_a)
        a_r <= load_data;
      else
        a_r <= a_nxt;
      if (state_r == lso_pkg::LSO_IDLE && !start && load_q)
        q_r <= load_data;
    end
  end

  // outputs come straight from flops; busy alone is decoded from
  // state so the sequencer sees it in the cycle after the take
  assign busy      = (state_r != lso_pkg::LSO_IDLE);
  assign done      = done_r;
  assign skip      = skip_r;
  assign overflow  = ovf_r;
  assign mem_we    = we_r;
  assign mem_wdata = wd_r;
  assign acc       = a_r;
  assign mask_q    = q_r;
endmodule // lso_logic_unit
`default_nettype wire

// ### lso_consts.svh
/*
  shared constants for the logical and selective datapath: word width,
  operation codes, skip designator codes and register reset values.
  assumes the sequencer decodes opcodes into these codes.
*/
`ifndef LSO_CONSTS_SVH
`define LSO_CONSTS_SVH
`define LSO_WORD_W      30
`define LSO_OP_W        4
`define LSO_OP_LOAD_AND   4'h0
`define LSO_OP_STORE_AND  4'h1
`define LSO_OP_WB_AND     4'h2
`define LSO_OP_ADD_MASK   4'h3
`define LSO_OP_SUB_MASK   4'h4
`define LSO_OP_WB_ADD     4'h5
`define LSO_OP_WB_SUB     4'h6
`define LSO_OP_SET        4'h7
`define LSO_OP_INVERT     4'h8
`define LSO_OP_ZEROS      4'h9
`define LSO_OP_MERGE      4'ha
`define LSO_OP_WB_SET     4'hb
`define LSO_OP_WB_INVERT  4'hc
`define LSO_OP_WB_ZEROS   4'hd
`define LSO_OP_WB_MERGE   4'he
`define LSO_SKIP_W      3
`define LSO_SKIP_NONE   3'h0
`define LSO_SKIP_ALWAYS 3'h1
`define LSO_SKIP_SKIP_IF_MASK_REG_POSITIVE   3'h2
`define LSO_SKIP_SKIP_IF_MASK_REG_NEGATIVE   3'h3
`define LSO_SKIP_AZERO  3'h4
`define LSO_SKIP_ANOT   3'h5
`define LSO_SKIP_APOS   3'h6
`define LSO_SKIP_ANEG   3'h7
`define LSO_A_RESET     30'h00000000
`define LSO_Q_RESET     30'h00000000
`endif

// ### lso_pkg.sv
/*
  types of the logical and selective datapath.
  assumes lso_consts.svh is on the include path.
*/
`include "lso_consts.svh"
package lso_pkg;
  // one-hot sequencing states
  typedef enum logic [4:0] {
    LSO_IDLE  = 5'b00001,
    LSO_STEP1 = 5'b00010,
    LSO_STEP2 = 5'b00100,
    LSO_STEP3 = 5'b01000,
    LSO_DONE  = 5'b10000
  } lso_state_t;
endpackage

// ### lso_alu_if.sv
/*
  interface between the sequencer core and the combinational alu.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lso_consts.svh"
interface lso_alu_if;
  logic [`LSO_WORD_W-1:0] a_in;    // accumulator value
  logic [`LSO_WORD_W-1:0] b_in;    // second term
  logic                   sub;     // subtract when high
  logic [`LSO_WORD_W-1:0] sum;     // ones-complement result
  logic                   ovf;     // overflow flag
  modport core (output a_in, output b_in, output sub,
                input sum, input ovf);
  modport alu  (input a_in, input b_in, input sub,
                output sum, output ovf);
endinterface
`default_nettype wire

// ### lso_oc_adder.sv
/*
  ones-complement adder/subtractor with end-around carry.
  assumes operands are ones-complement words of the shared width.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lso_consts.svh"
module lso_oc_adder (
  lso_alu_if.alu p
);
  localparam int W = `LSO_WORD_W;
  wire [W-1:0] b_eff;   // subtrahend is complemented
  wire [W:0]   raw;     // sum with carry out
  wire [W:0]   wrap;    // end-around carry added back
  // subtract by adding the complement, as the plain accumulator does
  assign b_eff = p.sub ? ~p.b_in : p.b_in;
  assign raw   = {1'b0, p.a_in} + {1'b0, b_eff};
  assign wrap  = {1'b0, raw[W-1:0]} + {{W{1'b0}}, raw[W]};
  assign p.sum = wrap[W-1:0];
  // like signs in, other sign out
  assign p.ovf = (p.a_in[W-1] == b_eff[W-1]) &&
                 (p.sum[W-1] != p.a_in[W-1]);
endmodule // lso_oc_adder
`default_nettype wire

// ### lso_logic_unit_props.sv
/*
  port checker for the logical and selective datapath.
  assumes op, skip code and operand stay held from start to done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lso_consts.svh"
module lso_unit_props #(parameter int WORD_W = `LSO_WORD_W) (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   start,
  input wire logic [`LSO_OP_W-1:0]   op,
  input wire logic [`LSO_SKIP_W-1:0] skip_code,
  input wire logic [WORD_W-1:0]      operand,
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic                   skip,
  input wire logic                   mem_we,
  input wire logic [WORD_W-1:0]      mem_wdata,
  input wire logic [WORD_W-1:0]      acc,
  input wire logic [WORD_W-1:0]      mask_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = start && !busy;  // accepted request
  // the two merge codes take the three step path
  wire mrg = op == `LSO_OP_MERGE || op == `LSO_OP_WB_MERGE;
  sequence s_short; busy ##1 done; endsequence
  sequence s_long; busy [*3] ##1 done; endsequence
  a_short_done: assert property (take && !mrg |=> s_short)
    else $error("short op not done in two cycles");
  a_merge_steps: assert property (take && mrg |=> s_long)
    else $error("merge op not done in four cycles");
  a_merge_res: assert property (take && mrg |-> ##4
    acc == (($past(acc, 4) & ~mask_q) | (operand & mask_q)))
    else $error("merge result wrong");
  a_load_and: assert property (take && op == `LSO_OP_LOAD_AND |->
    ##2 acc == (mask_q & operand)) else $error("masked load wrong");
  a_zero_sel: assert property (take && op == `LSO_OP_ZEROS |->
    ##2 acc == ($past(acc, 2) & ~operand)) else $error("clear wrong");
  a_store_and: assert property (take && op == `LSO_OP_STORE_AND |->
    ##1 mem_we && mem_wdata == (mask_q & acc)) else $error("store wrong");
  a_wb_merge: assert property (take && op == `LSO_OP_WB_MERGE |->
    ##3 mem_we && mem_wdata == (($past(acc, 3) & ~mask_q) |
    (operand & mask_q))) else $error("merge writeback wrong");
  a_we_pulse: assert property (mem_we |=> !mem_we)
    else $error("write strobe too long");
  a_even_skip: assert property (done && op == `LSO_OP_LOAD_AND &&
    skip_code == `LSO_SKIP_SKIP_IF_MASK_REG_POSITIVE |-> skip == ~^acc)
    else $error("parity skip wrong");
endmodule // lso_unit_props
bind lso_logic_unit lso_unit_props #(.WORD_W(WORD_W)) u_props (.clk_sys,
  .rst, .start, .op, .skip_code, .operand, .busy, .done, .skip, .mem_we,
  .mem_wdata, .acc, .mask_q);
`default_nettype wire

// ### lso_logic_unit_bench.sv
/*
  self-checking bench for the logical and selective datapath.
  assumes a 10 MHz clock and a behavioural model of a, q and overflow.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lso_consts.svh"
module lso_logic_unit_bench;
  logic clk_sys = 0, rst = 1, start = 0, load_a = 0, load_q = 0;
  logic [3:0] op = 4'h0;
  logic [2:0] skip_code = 3'h0;
  logic [29:0] operand = 30'h0, load_data = 30'h0;
  logic busy, done, skip, overflow, mem_we;
  logic [29:0] mem_wdata, acc, mask_q;
  logic [29:0] a_m = 30'h0, q_m = 30'h0, wb_d = 30'h0;  // model state
  logic ov_m = 0;
  int n_mismatch = 0, num_checks = 0, wb_cnt = 0, cyc = 0;
  lso_logic_unit DUT (.clk_sys, .rst, .start, .op, .skip_code, .operand,
    .load_a, .load_q, .load_data, .busy, .done, .skip, .overflow,
    .mem_we, .mem_wdata, .acc, .mask_q);
  always #50 clk_sys = ~clk_sys;
  // record each write strobe; mem_we is sampled before the edge updates
  always @(posedge clk_sys) begin
    if (mem_we === 1) begin
      wb_cnt <= wb_cnt + 1;
      wb_d <= mem_wdata;
    end
    cyc <= cyc + 1;
    // a hang anywhere ends the run as a mismatch
    if (cyc == 4000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  task automatic chk_w(input logic [29:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, e);
    chk_w({29'h0, g}, {29'h0, e});
  endtask
  // ones-complement sum with end-around carry, overflow in bit 30
  function automatic logic [30:0] ocadd(input logic [29:0] a, b);
    logic [30:0] s;
    s = {1'b0, a} + {1'b0, b};
    s = {1'b0, s[29:0]} + {30'h0, s[30]};
    return {a[29] == b[29] && s[29] != a[29], s[29:0]};
  endfunction
  task automatic ld(input logic la, lq, input logic [29:0] d);
    @(posedge clk_sys);
    load_a <= la;
    load_q <= lq;
    load_data <= d;
    @(posedge clk_sys);
    load_a <= 0;
    load_q <= 0;
    if (la) a_m = d;
    if (lq) q_m = d;
  endtask
  task automatic run(input logic [3:0] o, input logic [29:0] y,
                     input logic [2:0] sc);
    logic [29:0] r;
    logic [30:0] t;
    logic wb, sk, par;
    int n0;
    par = o == 4'h0 || o == 4'h2;
    wb = o inside {4'h1, 4'h2, 4'h5, 4'h6, [4'hb:4'he]};
    case (o)
      4'h0, 4'h2: r = q_m & y;
      4'h1: r = a_m;
      4'h3, 4'h5: t = ocadd(a_m, q_m & y);
      4'h4, 4'h6: t = ocadd(a_m, ~(q_m & y));
      4'h7, 4'hb: r = a_m | y;
      4'h8, 4'hc: r = a_m ^ y;
      4'h9, 4'hd: r = a_m & ~y;
      default: r = (a_m & ~q_m) | (y & q_m);
    endcase
    if (o inside {[4'h3:4'h6]}) begin
      r = t[29:0];
      ov_m = t[30];
    end
    // parity replaces the mask sign tests for the two masked loads
    case (sc)
      3'h0: sk = 0;
      3'h1: sk = 1;
      3'h2: sk = par ? ~^r : !q_m[29];
      3'h3: sk = par ? ^r : q_m[29];
      3'h4: sk = r == 30'h0;
      3'h5: sk = r != 30'h0;
      3'h6: sk = !r[29];
      default: sk = r[29];
    endcase
    @(posedge clk_sys);
    start <= 1;
    op <= o;
    operand <= y;
    skip_code <= sc;
    @(posedge clk_sys);
    n0 = wb_cnt;
    // loads offered while the op runs must be ignored
    load_a <= 1;
    load_q <= 1;
    load_data <= 30'($urandom);
    @(negedge clk_sys);
    chk_b(busy, 1);
    // start still high on this edge is a repeat the busy unit refuses
    @(posedge clk_sys);
    start <= 0;
    load_a <= 0;
    load_q <= 0;
    for (int n = 0; n < 8 && done !== 1; n++) @(negedge clk_sys);
    chk_b(done, 1);
    chk_b(busy, 0);
    chk_w(acc, r);
    chk_w(mask_q, q_m);
    chk_b(skip, sk);
    chk_b(overflow, ov_m);
    chk_b(wb_cnt != n0, wb);
    if (wb) chk_w(wb_d, o == 4'h1 ? q_m & a_m : r);
    a_m = r;
  endtask
  initial begin
    void'($urandom(44650));
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    // every output is cleared by reset
    @(negedge clk_sys);
    chk_w(acc, 30'h0);
    chk_w(mask_q, 30'h0);
    chk_b(done | mem_we | skip | overflow | busy, 0);
    // all-ones words back to back hit the negative zero corner
    ld(1, 1, 30'h3fffffff);
    for (int i = 0; i < 15; i++)
      run(4'(i), 30'h3fffffff, 3'((i + 2) % 8));
    run(4'h2, 30'($urandom), 3'h3);
    for (int i = 0; i < 90; i++) begin
      ld(1, 1, 30'($urandom));
      ld(0, 1, 30'($urandom));
      run(4'(i % 15), 30'($urandom), 3'($urandom % 8));
    end
    end_of_test;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // lso_logic_unit_bench
`default_nettype wire
